// [hdl/mic_irq_ctrl.sv]
`timescale 1ns/10ps
`default_nettype none
module mic_irq_ctrl (
	input  wire logic                           core_clk,
	input  wire logic                           resetn,
	input  wire logic [mic_pkg::ADDR_W-1:0]     reg_addr,
	input  wire logic [mic_pkg::DATA_W-1:0]     reg_wdata,
	input  wire logic                           reg_wr,
	input  wire logic                           reg_rd,
	input  wire logic                           reg_bit_wr,
	input  wire logic [2:0]                     reg_bit_idx,
	input  wire logic                           reg_bit_val,
	output logic      [mic_pkg::DATA_W-1:0]     reg_rdata,
	input  wire logic                           ext_irq_pin_zero_n,
	input  wire logic                           ext_irq_pin_one_n,
	input  wire logic                           timer_zero_overflow,
	input  wire logic                           timer_one_overflow,
	input  wire logic                           uart_pending,
	input  wire logic                           timer_two_low_overflow_flag,
	input  wire logic                           timer_two_high_overflow_flag,
	input  wire logic                           spi_pending,
	input  wire logic [mic_pkg::NUM_EXT-1:0]    ext_src_pending,
	input  wire logic [mic_pkg::NUM_EXT-1:0]    ext_src_enable,
	input  wire logic [mic_pkg::NUM_SRC-1:0]    src_high_priority,
	input  wire logic                           cpu_instr_done,
	input  wire logic                           cpu_return_from_irq_instruction,
	output logic                                irq_call,
	output logic                                irq_call_done,
	output logic      [mic_pkg::VEC_W-1:0]      irq_vector
);

	logic [1:0]                        rst_sync_ff;
	logic                              rst_n;
	logic [1:0]                        pin_n;
	logic [1:0]                        pin_fall;
	logic [mic_pkg::DATA_W-1:0]        interrupt_enable_mask_ff;
	logic [mic_pkg::NUM_OWN-1:0]       flag_ff;
	logic [mic_pkg::NUM_OWN-1:0]       nxt_flag;
	logic [mic_pkg::NUM_OWN-1:0]       flag_set;
	logic [mic_pkg::NUM_SRC-1:0]       pending;
	logic [mic_pkg::NUM_SRC-1:0]       enable_vec;
	logic [mic_pkg::NUM_SRC-1:0]       req_ff;
	logic [mic_pkg::NUM_SRC-1:0]       high_req;
	logic [mic_pkg::NUM_SRC-1:0]       low_req;
	logic [1:0]                        in_service_ff;
	logic                              take;
	logic                              take_high;
	logic [mic_pkg::SRC_IDX_W-1:0]     sel_src;
	logic                              call_start;
	mic_pkg::mic_call_state_t          state_ff;
	logic [mic_pkg::CNT_W-1:0]         call_cnt_ff;
	logic [mic_pkg::VEC_W-1:0]         vector_ff;
	logic [mic_pkg::DATA_W-1:0]        rdata_ff;
	logic [mic_pkg::DATA_W-1:0]        flag_view;
	logic [mic_pkg::DATA_W-1:0]        status_view;
	logic                              en_wr;
	logic                              en_bit_wr;
	logic                              flag_wr;
	logic                              flag_bit_wr;

	// reset release through two flops
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			rst_sync_ff <= 2'h0;
		end else begin
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_ff[1];

	// external pins: two-flop sync per pin, then falling edge
	assign pin_n = {ext_irq_pin_one_n, ext_irq_pin_zero_n};

	for (genvar g = 0; g < $bits(pin_n); g++) begin : g_pin
		logic meta_ff;
		logic sync_ff;
		logic prev_ff;

		// flops leave reset at the idle high level, so no false edge
		always_ff @(posedge core_clk or negedge rst_n) begin
			if (!rst_n) begin
				meta_ff <= 1'b1;
				sync_ff <= 1'b1;
				prev_ff <= 1'b1;
			end else begin
				meta_ff <= pin_n[g];
				sync_ff <= meta_ff;
				prev_ff <= sync_ff;
			end
		end
		assign pin_fall[g] = prev_ff & ~sync_ff;
	end

	// register decode
	assign en_wr       = reg_wr && (reg_addr == mic_pkg::ENABLE_ADDR);
	assign en_bit_wr   = reg_bit_wr && (reg_addr == mic_pkg::ENABLE_ADDR);
	assign flag_wr     = reg_wr && (reg_addr == mic_pkg::FLAG_ADDR);
	assign flag_bit_wr = reg_bit_wr && (reg_addr == mic_pkg::FLAG_ADDR);

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			interrupt_enable_mask_ff <= mic_pkg::ENABLE_RESET;
		end else if (en_wr) begin
			interrupt_enable_mask_ff <= reg_wdata;
		end else if (en_bit_wr) begin
			interrupt_enable_mask_ff[reg_bit_idx] <= reg_bit_val;
		end
	end

	// hardware-cleared pending flags of sources 0..3
	assign flag_set[mic_pkg::SRC_X0] = pin_fall[0];
	assign flag_set[mic_pkg::SRC_T0] = timer_zero_overflow;
	assign flag_set[mic_pkg::SRC_X1] = pin_fall[1];
	assign flag_set[mic_pkg::SRC_T1] = timer_one_overflow;

	always_comb begin
		nxt_flag = flag_ff;
		for (int i = 0; i < mic_pkg::NUM_OWN; i++) begin
			if (flag_wr) begin
				nxt_flag[i] = reg_wdata[mic_pkg::mic_flag_pos(2'(i))];
			end else if (flag_bit_wr && reg_bit_idx == mic_pkg::mic_flag_pos(2'(i))) begin
				nxt_flag[i] = reg_bit_val;
			end
			if (call_start && sel_src == 4'(i)) begin
				nxt_flag[i] = 1'b0;
			end
			// set last, so an event in the clearing cycle is kept
			if (flag_set[i]) begin
				nxt_flag[i] = 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			flag_ff <= mic_pkg::FLAG_RESET[mic_pkg::NUM_OWN-1:0];
		end else begin
			flag_ff <= nxt_flag;
		end
	end

	// pending and enable vectors in fixed priority order
	always_comb begin
		pending = '0;
		pending[mic_pkg::NUM_OWN-1:0] = flag_ff;
		pending[mic_pkg::SRC_UART] = uart_pending;
		pending[mic_pkg::SRC_T2] = timer_two_low_overflow_flag | timer_two_high_overflow_flag;
		pending[mic_pkg::SRC_SPI] = spi_pending;
		pending[mic_pkg::NUM_SRC-1:mic_pkg::SRC_EXT0] = ext_src_pending;
		pending[mic_pkg::SRC_RSVD] = 1'b0;
	end

	always_comb begin
		enable_vec = '0;
		enable_vec[mic_pkg::SRC_X0] = interrupt_enable_mask_ff[mic_pkg::EN_X0_BIT];
		enable_vec[mic_pkg::SRC_T0] = interrupt_enable_mask_ff[mic_pkg::EN_T0_BIT];
		enable_vec[mic_pkg::SRC_X1] = interrupt_enable_mask_ff[mic_pkg::EN_X1_BIT];
		enable_vec[mic_pkg::SRC_T1] = interrupt_enable_mask_ff[mic_pkg::EN_T1_BIT];
		enable_vec[mic_pkg::SRC_UART] = interrupt_enable_mask_ff[mic_pkg::EN_UART_BIT];
		enable_vec[mic_pkg::SRC_T2] = interrupt_enable_mask_ff[mic_pkg::EN_T2_BIT];
		enable_vec[mic_pkg::SRC_SPI] = interrupt_enable_mask_ff[mic_pkg::EN_SPI_BIT];
		enable_vec[mic_pkg::NUM_SRC-1:mic_pkg::SRC_EXT0] = ext_src_enable;
		enable_vec[mic_pkg::SRC_RSVD] = 1'b0;
	end

	// detect cycle: registered request, sampled every clock
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			req_ff <= '0;
		end else if (interrupt_enable_mask_ff[mic_pkg::EN_GLOBAL_BIT]) begin
			req_ff <= pending & enable_vec;
		end else begin
			req_ff <= '0;
		end
	end

	// two-level arbitration, fixed order inside a level
	assign high_req = req_ff & src_high_priority;
	assign low_req  = req_ff & ~src_high_priority;

	always_comb begin
		take = 1'b0;
		take_high = 1'b0;
		sel_src = '0;
		if ((|high_req) && !in_service_ff[mic_pkg::ST_HIGH_BIT]) begin
			take = 1'b1;
			take_high = 1'b1;
			sel_src = mic_pkg::mic_first_src(high_req);
		end else if ((|low_req) && (in_service_ff == 2'h0)) begin
			take = 1'b1;
			sel_src = mic_pkg::mic_first_src(low_req);
		end
	end

	// calls only at a boundary that is not the end of a return
	assign call_start = take && cpu_instr_done && !cpu_return_from_irq_instruction && (state_ff == mic_pkg::MIC_IDLE);

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= mic_pkg::MIC_IDLE;
			call_cnt_ff <= mic_pkg::CNT_ZERO;
		end else begin
			unique case (state_ff)
				mic_pkg::MIC_IDLE: begin
					if (call_start) begin
						state_ff <= mic_pkg::MIC_CALL;
						call_cnt_ff <= mic_pkg::CNT_ZERO;
					end
				end
				mic_pkg::MIC_CALL: begin
					if (call_cnt_ff == mic_pkg::CALL_LAST) begin
						state_ff <= mic_pkg::MIC_IDLE;
						call_cnt_ff <= mic_pkg::CNT_ZERO;
					end else begin
						call_cnt_ff <= call_cnt_ff + mic_pkg::CNT_ONE;
					end
				end
				default: begin
					state_ff <= mic_pkg::MIC_IDLE;
					call_cnt_ff <= mic_pkg::CNT_ZERO;
				end
			endcase
		end
	end

	assign irq_call      = (state_ff == mic_pkg::MIC_CALL);
	assign irq_call_done = irq_call && (call_cnt_ff == mic_pkg::CALL_LAST);

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			vector_ff <= mic_pkg::RESET_VECTOR;
		end else if (call_start) begin
			vector_ff <= mic_pkg::VECTOR_BASE + mic_pkg::VECTOR_STEP * 16'(sel_src);
		end
	end
	assign irq_vector = vector_ff;

	// in-service levels; a return retires the highest active level
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			in_service_ff <= 2'h0;
		end else if (call_start) begin
			if (take_high) begin
				in_service_ff[mic_pkg::ST_HIGH_BIT] <= 1'b1;
			end else begin
				in_service_ff[mic_pkg::ST_LOW_BIT] <= 1'b1;
			end
		end else if (cpu_instr_done && cpu_return_from_irq_instruction) begin
			if (in_service_ff[mic_pkg::ST_HIGH_BIT]) begin
				in_service_ff[mic_pkg::ST_HIGH_BIT] <= 1'b0;
			end else begin
				in_service_ff[mic_pkg::ST_LOW_BIT] <= 1'b0;
			end
		end
	end

	// read side
	always_comb begin
		flag_view = '0;
		for (int i = 0; i < mic_pkg::NUM_OWN; i++) begin
			flag_view[mic_pkg::mic_flag_pos(2'(i))] = flag_ff[i];
		end
	end

	always_comb begin
		status_view = '0;
		status_view[mic_pkg::ST_LOW_BIT] = in_service_ff[mic_pkg::ST_LOW_BIT];
		status_view[mic_pkg::ST_HIGH_BIT] = in_service_ff[mic_pkg::ST_HIGH_BIT];
		status_view[mic_pkg::ST_CALL_BIT] = irq_call;
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_ff <= mic_pkg::RDATA_IDLE;
		end else if (reg_rd) begin
			unique case (reg_addr)
				mic_pkg::ENABLE_ADDR: rdata_ff <= interrupt_enable_mask_ff;
				mic_pkg::FLAG_ADDR:   rdata_ff <= flag_view;
				mic_pkg::STATUS_ADDR: rdata_ff <= status_view;
				default:              rdata_ff <= mic_pkg::RDATA_IDLE;
			endcase
		end else begin
			rdata_ff <= mic_pkg::RDATA_IDLE;
		end
	end
	assign reg_rdata = rdata_ff;

endmodule // mic_irq_ctrl
`default_nettype wire

// [include/mic_pkg.sv]
`default_nettype none
package mic_pkg;
	localparam int ADDR_W     = 8;
	localparam int DATA_W     = 8;
	localparam int NUM_SRC    = 15;
	localparam int SRC_IDX_W  = 4;
	localparam int VEC_W      = 16;
	localparam int NUM_OWN    = 4;
	localparam int NUM_EXT    = 8;
	localparam int CNT_W      = 3;

	// register map
	localparam logic [7:0] ENABLE_ADDR  = 8'hA8;
	localparam logic [7:0] FLAG_ADDR    = 8'h88;
	localparam logic [7:0] STATUS_ADDR  = 8'hB1;
	localparam logic [7:0] ENABLE_RESET = 8'h00;
	localparam logic [7:0] FLAG_RESET   = 8'h00;
	localparam logic [7:0] RDATA_IDLE   = 8'h00;

	// enable register fields
	localparam int EN_GLOBAL_BIT = 7;
	localparam int EN_SPI_BIT    = 6;
	localparam int EN_T2_BIT     = 5;
	localparam int EN_UART_BIT   = 4;
	localparam int EN_T1_BIT     = 3;
	localparam int EN_X1_BIT     = 2;
	localparam int EN_T0_BIT     = 1;
	localparam int EN_X0_BIT     = 0;

	// flag register fields
	localparam logic [2:0] FLAG_X0_BIT = 3'h1;
	localparam logic [2:0] FLAG_X1_BIT = 3'h3;
	localparam logic [2:0] FLAG_T0_BIT = 3'h5;
	localparam logic [2:0] FLAG_T1_BIT = 3'h7;

	// status register fields
	localparam int ST_LOW_BIT  = 0;
	localparam int ST_HIGH_BIT = 1;
	localparam int ST_CALL_BIT = 2;

	// source indices in fixed priority order
	localparam int SRC_X0   = 0;
	localparam int SRC_T0   = 1;
	localparam int SRC_X1   = 2;
	localparam int SRC_T1   = 3;
	localparam int SRC_UART = 4;
	localparam int SRC_T2   = 5;
	localparam int SRC_SPI  = 6;
	localparam int SRC_EXT0 = 7;
	localparam int SRC_RSVD = 13;

	localparam logic [VEC_W-1:0] RESET_VECTOR = 16'h0000;
	localparam logic [VEC_W-1:0] VECTOR_BASE  = 16'h0003;
	localparam logic [VEC_W-1:0] VECTOR_STEP  = 16'h0008;

	// response timing in core clock cycles
	localparam int DETECT_CYCLES = 1;
	localparam int CALL_CYCLES   = 4;
	localparam int MIN_RESPONSE  = DETECT_CYCLES + CALL_CYCLES;
	localparam logic [CNT_W-1:0] CALL_LAST = 3'(CALL_CYCLES - 1);
	localparam logic [CNT_W-1:0] CNT_ZERO  = 3'h0;
	localparam logic [CNT_W-1:0] CNT_ONE   = 3'h1;

	typedef enum logic [1:0] {
		MIC_IDLE = 2'h0,
		MIC_CALL = 2'h1
	} mic_call_state_t;

	function automatic logic [2:0] mic_flag_pos(input logic [1:0] src);
		logic [2:0] p;
		p = FLAG_X0_BIT;
		unique case (src)
			2'h0: p = FLAG_X0_BIT;
			2'h1: p = FLAG_T0_BIT;
			2'h2: p = FLAG_X1_BIT;
			2'h3: p = FLAG_T1_BIT;
		endcase
		return p;
	endfunction

	function automatic logic [SRC_IDX_W-1:0] mic_first_src(input logic [NUM_SRC-1:0] v);
		logic [SRC_IDX_W-1:0] r;
		r = 4'h0;
		for (int i = NUM_SRC - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = 4'(i);
			end
		end
		return r;
	endfunction
endpackage
`default_nettype wire

// [dv/mic_irq_ctrl_checker.sv]
`timescale 1ns/10ps
`default_nettype none
module mic_irq_ctrl_checker (
	input wire logic        core_clk,
	input wire logic        resetn,
	input wire logic [7:0]  reg_addr,
	input wire logic [7:0]  reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic        reg_bit_wr,
	input wire logic [2:0]  reg_bit_idx,
	input wire logic        reg_bit_val,
	input wire logic [7:0]  reg_rdata,
	input wire logic        cpu_instr_done,
	input wire logic        cpu_return_from_irq_instruction,
	input wire logic        irq_call,
	input wire logic        irq_call_done,
	input wire logic [15:0] irq_vector
);
	logic [7:0] en_ff;

	// shadow of the enable register
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			en_ff <= 8'h00;
		end else if (reg_wr && reg_addr == 8'hA8) begin
			en_ff <= reg_wdata;
		end else if (reg_bit_wr && reg_addr == 8'hA8) begin
			en_ff[reg_bit_idx] <= reg_bit_val;
		end
	end

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!resetn);

	call_length_a: assert property ($rose(irq_call) |-> irq_call[*4] ##1 !irq_call)
		else $error("call length wrong");
	call_done_a: assert property ($rose(irq_call) |-> !irq_call_done[*3] ##1 irq_call_done)
		else $error("call done misplaced");
	done_inside_a: assert property (irq_call_done |-> irq_call && !$past(irq_call_done))
		else $error("call done outside call");
	global_gate_a: assert property ($rose(irq_call) |-> $past(en_ff[7], 2))
		else $error("call with global enable off");
	boundary_a: assert property ($rose(irq_call) |-> $past(cpu_instr_done) && !$past(cpu_return_from_irq_instruction))
		else $error("call not on plain boundary");
	vector_map_a: assert property ($rose(irq_call) |->
		irq_vector[2:0] == 3'h3 && irq_vector <= 16'h0073 && irq_vector != 16'h006B)
		else $error("vector off map");
	vector_hold_a: assert property (!$rose(irq_call) |-> $stable(irq_vector))
		else $error("vector moved outside call");
	rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data not idle");
	enable_read_a: assert property ($past(reg_rd) && $past(reg_addr) == 8'hA8 |-> reg_rdata == en_ff)
		else $error("enable read back wrong");
endmodule // mic_irq_ctrl_checker
`default_nettype wire

// [dv/mic_cpu_model.sv]
`timescale 1ns/10ps
`default_nettype none
module mic_cpu_model (
	input wire logic       core_clk,
	input wire logic       resetn,
	input wire logic       irq_call,
	input wire logic       ret_go,
	input wire logic [3:0] instr_len,
	output logic           cpu_instr_done,
	output logic           cpu_return_from_irq_instruction
);
	logic [3:0] cnt_ff;
	logic       ret_ff;

	// no instruction completes while the call runs
	assign cpu_instr_done = !irq_call && (cnt_ff == instr_len - 4'h1);
	assign cpu_return_from_irq_instruction = ret_ff;

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			cnt_ff <= 4'h0;
		end else if (cpu_instr_done) begin
			cnt_ff <= 4'h0;
		end else if (!irq_call) begin
			cnt_ff <= cnt_ff + 4'h1;
		end
	end

	// next completed instruction is the return
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			ret_ff <= 1'b0;
		end else if (ret_go) begin
			ret_ff <= 1'b1;
		end else if (cpu_instr_done) begin
			ret_ff <= 1'b0;
		end
	end
endmodule // mic_cpu_model
`default_nettype wire

// [dv/mic_irq_ctrl_test.sv]
`timescale 1ns/10ps
`default_nettype none
module mic_irq_ctrl_test;
	logic        core_clk = 1'b0;
	logic        resetn = 1'b0;
	logic [7:0]  reg_addr = 8'h00;
	logic [7:0]  reg_wdata = 8'h00;
	logic [7:0]  reg_rdata;
	logic        reg_wr = 1'b0, reg_rd = 1'b0, reg_bit_wr = 1'b0, reg_bit_val = 1'b0;
	logic [2:0]  reg_bit_idx = 3'h0;
	logic        ext_irq_pin_zero_n = 1'b1, ext_irq_pin_one_n = 1'b1;
	logic        timer_zero_overflow = 1'b0, timer_one_overflow = 1'b0;
	logic        uart_pending = 1'b0, spi_pending = 1'b0;
	logic        timer_two_low_overflow_flag = 1'b0, timer_two_high_overflow_flag = 1'b0;
	logic [7:0]  ext_src_pending = 8'h00, ext_src_enable = 8'h00;
	logic [14:0] src_high_priority = 15'h0000;
	logic [3:0]  instr_len = 4'h1;
	logic        ret_go = 1'b0;
	logic        cpu_instr_done, cpu_return_from_irq_instruction, irq_call, irq_call_done;
	logic [15:0] irq_vector;
	int          miscompares = 0, comparisons = 0, cycles = 0;

	always #20 core_clk = ~core_clk;

	mic_irq_ctrl uut (.core_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_bit_wr,
		.reg_bit_idx, .reg_bit_val, .reg_rdata, .ext_irq_pin_zero_n, .ext_irq_pin_one_n,
		.timer_zero_overflow, .timer_one_overflow, .uart_pending, .timer_two_low_overflow_flag,
		.timer_two_high_overflow_flag, .spi_pending, .ext_src_pending, .ext_src_enable,
		.src_high_priority, .cpu_instr_done, .cpu_return_from_irq_instruction, .irq_call, .irq_call_done, .irq_vector);
	mic_cpu_model cpu (.core_clk, .resetn, .irq_call, .ret_go, .instr_len, .cpu_instr_done,
		.cpu_return_from_irq_instruction);

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task test_done;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			test_done();
		end
	end

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic bitw(input logic [7:0] a, input logic [2:0] i, input logic v);
		@(posedge core_clk);
		reg_addr <= a;
		reg_bit_idx <= i;
		reg_bit_val <= v;
		reg_bit_wr <= 1'b1;
		@(posedge core_clk);
		reg_bit_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		check(reg_rdata, exp);
	endtask
	task automatic trig(input int i);
		@(posedge core_clk);
		case (i)
			0: ext_irq_pin_zero_n <= 1'b0;
			1: timer_zero_overflow <= 1'b1;
			2: ext_irq_pin_one_n <= 1'b0;
			3: timer_one_overflow <= 1'b1;
			4: uart_pending <= 1'b1;
			5: timer_two_high_overflow_flag <= 1'b1;
			default: spi_pending <= 1'b1;
		endcase
		@(posedge core_clk);
		{ext_irq_pin_zero_n, ext_irq_pin_one_n, timer_zero_overflow, timer_one_overflow} <= 4'hC;
	endtask
	task automatic wait_call(input logic [15:0] exp);
		int n;
		n = 0;
		while (irq_call !== 1'b1 && n < 40) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		check(irq_call, 1'b1);
		check(irq_vector, exp);
		while (irq_call === 1'b1) begin
			@(posedge core_clk);
			#1;
		end
	endtask
	task automatic no_call(input int n);
		repeat (n) begin
			@(posedge core_clk);
			#1;
			check(irq_call, 1'b0);
		end
	endtask
	task automatic return_from_irq_instruction;
		@(posedge core_clk);
		ret_go <= 1'b1;
		@(posedge core_clk);
		ret_go <= 1'b0;
		#1;
		while (cpu_return_from_irq_instruction === 1'b1) begin
			@(posedge core_clk);
			#1;
		end
	endtask

	task t_regs;
		rd(8'hA8, 8'h00);
		wr(8'hA8, 8'h81);
		rd(8'hA8, 8'h81);
		bitw(8'hA8, 3'h4, 1'b1);
		bitw(8'hA8, 3'h0, 1'b0);
		rd(8'hA8, 8'h90);
		wr(8'h55, 8'hFF);
		rd(8'h55, 8'h00);
		wr(8'hA8, 8'h00);
		$display("register test done");
	endtask
	task t_latency;
		int n;
		wr(8'hA8, 8'h82);
		@(posedge core_clk);
		timer_zero_overflow <= 1'b1;
		@(posedge core_clk);
		timer_zero_overflow <= 1'b0;
		n = 0;
		do begin
			@(posedge core_clk);
			#1;
			n++;
		end while (irq_call_done !== 1'b1 && n < 20);
		check(16'(n), 16'h0005);
		check(irq_vector, 16'h000B);
		rd(8'h88, 8'h00);
		return_from_irq_instruction();
		wr(8'hA8, 8'h00);
		$display("latency test done");
	endtask
	task t_mask;
		wr(8'hA8, 8'h7F);
		trig(1);
		uart_pending <= 1'b1;
		no_call(12);
		rd(8'h88, 8'h20);
		@(posedge core_clk);
		uart_pending <= 1'b0;
		wr(8'h88, 8'h00);
		bitw(8'h88, 3'h1, 1'b1);
		bitw(8'hA8, 3'h7, 1'b1);
		wait_call(16'h0003);
		rd(8'h88, 8'h00);
		return_from_irq_instruction();
		@(posedge core_clk);
		ext_src_enable <= 8'h01;
		ext_src_pending <= 8'h01;
		wait_call(16'h003B);
		@(posedge core_clk);
		ext_src_pending <= 8'h00;
		return_from_irq_instruction();
		wr(8'hA8, 8'h00);
		$display("mask test done");
	endtask
	task t_gates;
		for (int i = 0; i < 7; i++) begin
			wr(8'hA8, 8'hFF & ~(8'h01 << i));
			trig(i);
			no_call(10);
			bitw(8'hA8, 3'(i), 1'b1);
			wait_call(16'h0003 + 16'(8 * i));
			if (i == 4) begin
				return_from_irq_instruction();
				wait_call(16'h0023);
			end
			@(posedge core_clk);
			{uart_pending, timer_two_high_overflow_flag, spi_pending} <= 3'h0;
			return_from_irq_instruction();
		end
		wr(8'hA8, 8'hA0);
		timer_two_low_overflow_flag <= 1'b1;
		wait_call(16'h002B);
		@(posedge core_clk);
		timer_two_low_overflow_flag <= 1'b0;
		return_from_irq_instruction();
		wr(8'hA8, 8'h00);
		$display("gate test done");
	endtask
	task t_prio;
		int n;
		instr_len <= 4'h3;
		trig(1);
		trig(2);
		wr(8'hA8, 8'h86);
		wait_call(16'h000B);
		no_call(8);
		@(posedge core_clk);
		src_high_priority <= 15'h0004;
		wait_call(16'h0013);
		rd(8'hB1, 8'h03);
		rd(8'h88, 8'h00);
		trig(1);
		return_from_irq_instruction();
		no_call(8);
		return_from_irq_instruction();
		// one more three-cycle instruction must pass before the call
		n = 0;
		while (irq_call !== 1'b1 && n < 40) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		check(16'(n), 16'h0003);
		wait_call(16'h000B);
		return_from_irq_instruction();
		@(posedge core_clk);
		src_high_priority <= 15'h0000;
		instr_len <= 4'h1;
		wr(8'hA8, 8'h00);
		$display("priority test done");
	endtask

	initial begin
		repeat (6) @(posedge core_clk);
		resetn <= 1'b1;
		repeat (4) @(posedge core_clk);
		t_regs();
		t_latency();
		t_mask();
		t_gates();
		t_prio();
		test_done();
	end
endmodule // mic_irq_ctrl_test
bind mic_irq_ctrl mic_irq_ctrl_checker chk (.core_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr,
	.reg_rd, .reg_bit_wr, .reg_bit_idx, .reg_bit_val, .reg_rdata, .cpu_instr_done, .cpu_return_from_irq_instruction,
	.irq_call, .irq_call_done, .irq_vector);
`default_nettype wire
